/* brio_ctl.sv */
// Boot ROM fault-recovery remap and programmable I/O cycle timing
//
// Overview of operation
// - Slot two control reads fixed recovery value
// - Reset write protection survives the remap
// - Boot block blocked at alternate location
// - Slot two is double-sided 85 ns flash
// - Slot two uses mux mode four
// - Mask zero, EDO normal, no interleave
// - Slot two base field places module
// - Protected writes end without writing
// - Timing, ready and timeout need enable
// - Read length 1 to 16 clocks
// - Write length 1 to 16 clocks
// - Read-only flag on ready timeout
// - Timeout field sets maximum ready wait
// - Timeout ends cycle with zero data
// - Timeout field resets to fifteen clocks
// - Top six bits read zero
// - Recovery strap maps boot range to slot
`timescale 1ns/1ps
module brio_ctl (
	input  wire logic        MCLK,
	input  wire logic        RESET_N,
	// Reset straps on the multiplexed address/data bus
	input  wire logic [8:0]  MUXED_ADDR_DATA_BUS,
	// Register access in system memory space
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	output logic      [31:0] REG_RDATA,
	// Boot ROM range cycle request
	input  wire logic        CYC_REQ,
	input  wire logic        CYC_WRITE,
	input  wire logic [31:0] CYC_ADDR,
	input  wire logic [31:0] CYC_WDATA,
	output logic             CYC_BUSY,
	output logic             CYC_DONE,
	output logic             CYC_ERR,
	output logic      [31:0] CYC_RDATA,
	// Memory bus pins
	input  wire logic        IOCHRDY,
	output logic             ROM_CS_N,
	output logic             SECOND_MODULE_SLOT_CS_N,
	output logic             MEM_OE_N,
	output logic             MEM_WE_N,
	output logic      [31:0] MEM_ADDR,
	input  wire logic [31:0] MEM_DQ_IN,
	output logic      [31:0] MEM_DQ_OUT,
	output logic             MEM_DQ_OE,
	// Second module slot configuration
	output logic             FAULT_RECOVERY,
	output logic      [1:0]  SECOND_MODULE_SLOT_TYPE,
	output logic             SECOND_MODULE_SLOT_DOUBLE_SIDED,
	output logic             SECOND_MODULE_SLOT_EN,
	output logic             SECOND_MODULE_SLOT_MUX_MODE4,
	output logic      [1:0]  SECOND_MODULE_SLOT_MUX_MODE,
	output logic             SECOND_MODULE_SLOT_EDO_ID_MODE,
	output logic             SECOND_MODULE_SLOT_BANK_INTERLEAVE,
	output logic      [7:0]  SECOND_MODULE_SLOT_ADDR_MASK,
	output logic      [7:0]  SECOND_MODULE_SLOT_BASE_ADDR,
	output logic      [3:0]  SECOND_MODULE_SLOT_ACCESS_CLKS
);
	typedef struct packed {
		logic [1:0]          settle;
		logic                cfg_done;
		logic                fault_rec;
		logic [2:0]          rom_size;
		logic [3:0]          prot;
		logic [3:0]          rd_time;
		logic [3:0]          wr_time;
		logic                tim_en;
		logic [15:0]         ready_max_wait_count;
		logic                io_device_timeout_flag;
		logic [31:0]         second_module_slot_ctl;
		logic [31:0]         rdata;
		brio_pkg::brio_cyc_e cyc;
		logic [3:0]          min_cnt;
		logic [15:0]         wait_cnt;
		logic                is_write;
		logic                rom_cs;
		logic                second_module_slot_cs;
		logic                oe;
		logic                we;
		logic [31:0]         addr;
		logic [31:0]         wdata;
		logic [31:0]         cyc_rdata;
		logic                done;
		logic                err;
	} brio_ctl_s;

	brio_ctl_s   st;
	brio_ctl_s   next_st;
	logic [8:0]  strap_s;
	logic        ready_s;
	logic [31:0] dq_s;
	logic        in_window;
	logic        in_rom;
	logic        to_second_module_slot;
	logic        protect;
	logic [31:0] iotim;

	brio_sync #(.W(9)) u_strap_sync (
		.clk   (MCLK),
		.rst_n (RESET_N),
		.d     (MUXED_ADDR_DATA_BUS),
		.q     (strap_s)
	);

	brio_sync #(.W(33)) u_bus_sync (
		.clk   (MCLK),
		.rst_n (RESET_N),
		.d     ({IOCHRDY, MEM_DQ_IN}),
		.q     ({ready_s, dq_s})
	);

	brio_rom_decode u_decode (
		.addr      (CYC_ADDR),
		.rom_size  (st.rom_size),
		.prot      (st.prot),
		.fault_rec (st.fault_rec),
		.in_window (in_window),
		.in_rom    (in_rom),
		.to_second_module_slot  (to_second_module_slot),
		.protect   (protect)
	);

	// Register image, upper bits hardwired to zero
	always_comb begin
		iotim                                     = '0;
		iotim[brio_pkg::RD_MSB:brio_pkg::RD_LSB]     = st.rd_time;
		iotim[brio_pkg::EN_BIT]                      = st.tim_en;
		iotim[brio_pkg::WR_MSB:brio_pkg::WR_LSB]     = st.wr_time;
		iotim[brio_pkg::ERR_BIT]                     = st.io_device_timeout_flag;
		iotim[brio_pkg::MAXW_MSB:brio_pkg::MAXW_LSB] = st.ready_max_wait_count;
	end

	always_comb begin
		next_st      = st;
		next_st.done = 1'b0;
		next_st.err  = 1'b0;

		// Catch the straps once the synchroniser has settled after reset
		if (!st.cfg_done) begin
			if (st.settle == brio_pkg::STRAP_SETTLE) begin
				next_st.cfg_done  = 1'b1;
				next_st.fault_rec = strap_s[brio_pkg::STRAP_FR_BIT];
				next_st.rom_size  = strap_s[brio_pkg::STRAP_SIZE_MSB:brio_pkg::STRAP_SIZE_LSB];
				next_st.prot      = strap_s[brio_pkg::STRAP_PROT_MSB:brio_pkg::STRAP_PROT_LSB];
			end else begin
				next_st.settle = st.settle + 2'h1;
			end
		end

		// Register writes; the timeout flag is not writable
		if (REG_WR) begin
			if (REG_ADDR == brio_pkg::IOTIM_OFFSET) begin
				next_st.rd_time              = REG_WDATA[brio_pkg::RD_MSB:brio_pkg::RD_LSB];
				next_st.tim_en               = REG_WDATA[brio_pkg::EN_BIT];
				next_st.wr_time              = REG_WDATA[brio_pkg::WR_MSB:brio_pkg::WR_LSB];
				next_st.ready_max_wait_count = REG_WDATA[brio_pkg::MAXW_MSB:brio_pkg::MAXW_LSB];
			end else if (REG_ADDR == brio_pkg::SECOND_MODULE_SLOT_CTL_OFFSET) begin
				next_st.second_module_slot_ctl = REG_WDATA;
			end
		end

		// Register reads
		if (REG_RD) begin
			if (REG_ADDR == brio_pkg::IOTIM_OFFSET) begin
				next_st.rdata = iotim;
			end else if (REG_ADDR == brio_pkg::SECOND_MODULE_SLOT_CTL_OFFSET) begin
				next_st.rdata = st.fault_rec ? brio_pkg::SECOND_MODULE_SLOT_FR_VALUE : st.second_module_slot_ctl;
			end else begin
				next_st.rdata = '0;
			end
		end

		// Boot range cycle engine
		case (st.cyc)
			brio_pkg::ST_IDLE: begin
				if (CYC_REQ && st.cfg_done) begin
					next_st.is_write  = CYC_WRITE;
					next_st.addr      = CYC_ADDR;
					next_st.wdata     = CYC_WDATA;
					next_st.cyc_rdata = '0;
					next_st.io_device_timeout_flag = 1'b0;
					if (!in_window || (!to_second_module_slot && !in_rom)) begin
						next_st.err = 1'b1;
						next_st.cyc = brio_pkg::ST_DONE;
					end else if (CYC_WRITE && protect) begin
						next_st.cyc = brio_pkg::ST_DONE;
					end else begin
						next_st.rom_cs   = !to_second_module_slot;
						next_st.second_module_slot_cs = to_second_module_slot;
						next_st.oe       = !CYC_WRITE;
						next_st.we       = CYC_WRITE;
						next_st.min_cnt  = CYC_WRITE ? st.wr_time : st.rd_time;
						next_st.wait_cnt = st.ready_max_wait_count;
						if (st.tim_en) begin
							next_st.cyc = brio_pkg::ST_MIN;
						end else begin
							next_st.cyc = brio_pkg::ST_DONE;
						end
					end
				end
			end
			brio_pkg::ST_MIN: begin
				if (st.min_cnt != 4'h0) begin
					next_st.min_cnt = st.min_cnt - 4'h1;
				end else if (ready_s) begin
					next_st.cyc = brio_pkg::ST_DONE;
				end else begin
					next_st.cyc = brio_pkg::ST_WAIT;
				end
			end
			brio_pkg::ST_WAIT: begin
				if (ready_s) begin
					next_st.cyc = brio_pkg::ST_DONE;
				end else if (st.wait_cnt == 16'h0000) begin
					next_st.io_device_timeout_flag = 1'b1;
					next_st.err                    = 1'b1;
					next_st.cyc                    = brio_pkg::ST_DONE;
				end else begin
					next_st.wait_cnt = st.wait_cnt - 16'h0001;
				end
			end
			brio_pkg::ST_DONE: begin
				// Timeout leaves the read data at zero
				if (st.oe && !st.io_device_timeout_flag) begin
					next_st.cyc_rdata = dq_s;
				end else begin
					next_st.cyc_rdata = '0;
				end
				next_st.rom_cs   = 1'b0;
				next_st.second_module_slot_cs = 1'b0;
				next_st.oe       = 1'b0;
				next_st.we       = 1'b0;
				next_st.done     = 1'b1;
				next_st.err      = st.err;
				next_st.cyc      = brio_pkg::ST_IDLE;
			end
			default: begin
				next_st.cyc = brio_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			st                        <= '0;
			st.rd_time                <= brio_pkg::RD_RESET;
			st.wr_time                <= brio_pkg::WR_RESET;
			st.tim_en                 <= brio_pkg::EN_RESET;
			st.ready_max_wait_count   <= brio_pkg::MAXW_RESET;
			st.second_module_slot_ctl              <= brio_pkg::SECOND_MODULE_SLOT_CTL_RESET;
			st.cyc                    <= brio_pkg::ST_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign REG_RDATA  = st.rdata;
	assign CYC_BUSY   = (st.cyc != brio_pkg::ST_IDLE) || !st.cfg_done;
	assign CYC_DONE   = st.done;
	assign CYC_ERR    = st.done && st.err;
	assign CYC_RDATA  = st.cyc_rdata;
	assign ROM_CS_N   = !st.rom_cs;
	assign SECOND_MODULE_SLOT_CS_N = !st.second_module_slot_cs;
	assign MEM_OE_N   = !st.oe;
	assign MEM_WE_N   = !st.we;
	assign MEM_ADDR   = st.addr;
	assign MEM_DQ_OUT = st.wdata;
	assign MEM_DQ_OE  = st.we;

	// Fixed slot two setup while recovering
	assign FAULT_RECOVERY        = st.fault_rec;
	assign SECOND_MODULE_SLOT_TYPE            = st.fault_rec ? brio_pkg::SECOND_MODULE_SLOT_TYPE_FLASH : 2'h0;
	assign SECOND_MODULE_SLOT_DOUBLE_SIDED    = st.fault_rec & brio_pkg::SECOND_MODULE_SLOT_DOUBLE;
	assign SECOND_MODULE_SLOT_EN              = st.fault_rec & brio_pkg::SECOND_MODULE_SLOT_ENABLE;
	assign SECOND_MODULE_SLOT_MUX_MODE4       = st.fault_rec & brio_pkg::SECOND_MODULE_SLOT_MUX4;
	assign SECOND_MODULE_SLOT_MUX_MODE        = brio_pkg::SECOND_MODULE_SLOT_MUX_LOW;
	assign SECOND_MODULE_SLOT_EDO_ID_MODE     = brio_pkg::SECOND_MODULE_SLOT_EDO_ID;
	assign SECOND_MODULE_SLOT_BANK_INTERLEAVE = brio_pkg::SECOND_MODULE_SLOT_INTERLEAVE;
	assign SECOND_MODULE_SLOT_ADDR_MASK       = brio_pkg::SECOND_MODULE_SLOT_MASK;
	assign SECOND_MODULE_SLOT_BASE_ADDR       = st.fault_rec ? brio_pkg::SECOND_MODULE_SLOT_BASE : 8'h00;
	assign SECOND_MODULE_SLOT_ACCESS_CLKS     = st.fault_rec ? 4'(brio_pkg::FLASH_ACCESS_CLKS) : 4'h0;
endmodule

/* brio_pkg.sv */
// Constants and types shared by the boot ROM and I/O cycle timing block
package brio_pkg;

	// Clock and flash timing
	localparam int CLK_PERIOD_NS     = 20;
	localparam int FLASH_ACCESS_NS   = 85;
	localparam int FLASH_ACCESS_CLKS = (FLASH_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Register offsets in system memory space
	localparam logic [7:0] IOTIM_OFFSET     = 8'hE8;
	localparam logic [7:0] SECOND_MODULE_SLOT_CTL_OFFSET = 8'h18;

	// I/O cycle timing control fields
	localparam int RD_LSB   = 0;
	localparam int RD_MSB   = 3;
	localparam int EN_BIT   = 4;
	localparam int WR_LSB   = 5;
	localparam int WR_MSB   = 8;
	localparam int ERR_BIT  = 9;
	localparam int MAXW_LSB = 10;
	localparam int MAXW_MSB = 25;
	localparam logic [3:0]  RD_RESET   = 4'h0;
	localparam logic [3:0]  WR_RESET   = 4'h0;
	localparam logic        EN_RESET   = 1'b0;
	localparam logic [15:0] MAXW_RESET = 16'h000F;

	// Second module slot control in fault recovery
	localparam logic [31:0] SECOND_MODULE_SLOT_FR_VALUE   = 32'h1F00_100E;
	localparam logic [31:0] SECOND_MODULE_SLOT_CTL_RESET  = 32'h0000_0000;
	localparam logic [1:0]  SECOND_MODULE_SLOT_TYPE_FLASH = 2'h2;
	localparam logic        SECOND_MODULE_SLOT_DOUBLE     = 1'b1;
	localparam logic        SECOND_MODULE_SLOT_ENABLE     = 1'b1;
	localparam logic        SECOND_MODULE_SLOT_MUX4       = 1'b1;
	localparam logic [1:0]  SECOND_MODULE_SLOT_MUX_LOW    = 2'h0;
	localparam logic        SECOND_MODULE_SLOT_EDO_ID     = 1'b0;
	localparam logic        SECOND_MODULE_SLOT_INTERLEAVE = 1'b0;
	localparam logic [7:0]  SECOND_MODULE_SLOT_MASK       = 8'h00;
	localparam logic [7:0]  SECOND_MODULE_SLOT_BASE       = 8'h78;

	// Boot ROM address map
	localparam logic [5:0]  BOOT_WIN_TAG   = 6'h07;
	localparam logic [31:0] SMALL_ROM_BASE = 32'h1FC0_0000;
	localparam logic [32:0] ROM_TOP        = 33'h0_2000_0000;
	localparam logic [31:0] FR_SHIFT       = 32'h0100_0000;
	localparam logic [31:0] FR_LARGE_BASE  = 32'h1C00_0000;
	localparam logic [31:0] ROM_MIN_SIZE   = 32'h0008_0000;
	localparam logic [2:0]  SIZE_4MB       = 3'h3;
	localparam logic [2:0]  SIZE_16MB      = 3'h5;
	localparam int          BLOCK_SHIFT    = 16;
	localparam logic [3:0]  PROT_NONE      = 4'hF;

	// Reset strap positions on the multiplexed address/data bus
	localparam int STRAP_SIZE_LSB = 0;
	localparam int STRAP_SIZE_MSB = 2;
	localparam int STRAP_PROT_LSB = 3;
	localparam int STRAP_PROT_MSB = 6;
	localparam int STRAP_FR_BIT   = 8;
	localparam logic [1:0] STRAP_SETTLE = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MIN  = 2'b01,
		ST_WAIT = 2'b10,
		ST_DONE = 2'b11
	} brio_cyc_e;

endpackage

/* brio_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module brio_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} brio_sync_s;

	brio_sync_s st;
	brio_sync_s next_st;

	always_comb begin
		next_st    = st;
		next_st.s1 = d;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q = st.s2;
endmodule

/* brio_rom_decode.sv */
// Boot ROM window, remap and hardware write protection decode
`timescale 1ns/1ps
module brio_rom_decode (
	input  wire logic [31:0] addr,
	input  wire logic [2:0]  rom_size,
	input  wire logic [3:0]  prot,
	input  wire logic        fault_rec,
	output logic             in_window,
	output logic             in_rom,
	output logic             to_second_module_slot,
	output logic             protect
);
	logic [31:0] size_bytes;
	logic [31:0] base;
	logic [31:0] offs;
	logic [20:0] prot_bytes;

	always_comb begin
		size_bytes = brio_pkg::ROM_MIN_SIZE << rom_size;
		if (rom_size <= brio_pkg::SIZE_4MB) begin
			base = brio_pkg::SMALL_ROM_BASE;
		end else begin
			base = 32'(brio_pkg::ROM_TOP - {1'b0, size_bytes});
		end
		// Alternate location of the ROM image when remapped
		if (fault_rec) begin
			if (rom_size <= brio_pkg::SIZE_16MB) begin
				base = base - brio_pkg::FR_SHIFT;
			end else begin
				base = brio_pkg::FR_LARGE_BASE;
			end
		end
		offs       = addr - base;
		in_window  = (addr[31:26] == brio_pkg::BOOT_WIN_TAG);
		in_rom     = in_window && (addr >= base) && (offs < size_bytes);
		to_second_module_slot   = in_window && fault_rec;
		prot_bytes = 21'({1'b0, prot} + 5'h01) << brio_pkg::BLOCK_SHIFT;
		// Hardware protection follows the image to its alternate location
		protect    = in_rom && (prot != brio_pkg::PROT_NONE) && (offs < {11'h000, prot_bytes});
	end
endmodule

/* brio_ctl_properties.sv */
// Checker for the boot ROM and I/O cycle timing block
`timescale 1ns/1ps
module brio_ctl_props (
	input wire logic        MCLK,
	input wire logic        RESET_N,
	input wire logic        REG_RD,
	input wire logic [7:0]  REG_ADDR,
	input wire logic [31:0] REG_RDATA,
	input wire logic        CYC_BUSY,
	input wire logic        CYC_DONE,
	input wire logic        CYC_ERR,
	input wire logic [31:0] CYC_RDATA,
	input wire logic        ROM_CS_N,
	input wire logic        SECOND_MODULE_SLOT_CS_N,
	input wire logic        FAULT_RECOVERY,
	input wire logic [1:0]  SECOND_MODULE_SLOT_TYPE,
	input wire logic        SECOND_MODULE_SLOT_DOUBLE_SIDED,
	input wire logic        SECOND_MODULE_SLOT_EN,
	input wire logic        SECOND_MODULE_SLOT_MUX_MODE4,
	input wire logic [1:0]  SECOND_MODULE_SLOT_MUX_MODE,
	input wire logic        SECOND_MODULE_SLOT_EDO_ID_MODE,
	input wire logic        SECOND_MODULE_SLOT_BANK_INTERLEAVE,
	input wire logic [7:0]  SECOND_MODULE_SLOT_ADDR_MASK,
	input wire logic [7:0]  SECOND_MODULE_SLOT_BASE_ADDR,
	input wire logic [3:0]  SECOND_MODULE_SLOT_ACCESS_CLKS
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RESET_N);

	a_err_has_done: assert property (CYC_ERR |-> CYC_DONE)
		else $error("error pulse without done");
	a_err_zero_data: assert property (CYC_ERR |-> CYC_RDATA == 32'h0)
		else $error("error cycle returned data");
	a_done_single: assert property (CYC_DONE |=> !CYC_DONE)
		else $error("done longer than one cycle");
	a_strobe_busy: assert property ((!ROM_CS_N || !SECOND_MODULE_SLOT_CS_N) |-> CYC_BUSY)
		else $error("select while idle");
	a_slot_idle: assert property (!FAULT_RECOVERY |-> SECOND_MODULE_SLOT_CS_N)
		else $error("slot two selected outside recovery");
	a_slot_flash: assert property (FAULT_RECOVERY |-> SECOND_MODULE_SLOT_TYPE == 2'h2 && SECOND_MODULE_SLOT_DOUBLE_SIDED
		&& SECOND_MODULE_SLOT_EN && SECOND_MODULE_SLOT_ACCESS_CLKS == 4'h5) else $error("slot two not flash");
	a_slot_mux: assert property (FAULT_RECOVERY |-> SECOND_MODULE_SLOT_MUX_MODE4 && SECOND_MODULE_SLOT_MUX_MODE == 2'h0)
		else $error("slot two mux mode wrong");
	a_slot_window: assert property (FAULT_RECOVERY |-> SECOND_MODULE_SLOT_ADDR_MASK == 8'h00
		&& !SECOND_MODULE_SLOT_EDO_ID_MODE && !SECOND_MODULE_SLOT_BANK_INTERLEAVE) else $error("slot two window wrong");
	a_slot_base: assert property (FAULT_RECOVERY |-> SECOND_MODULE_SLOT_BASE_ADDR == 8'h78)
		else $error("slot two base wrong");
	a_top_zero: assert property (REG_RD && REG_ADDR == 8'hE8 |=> REG_RDATA[31:26] == 6'h0)
		else $error("timing word top bits set");
endmodule

bind brio_ctl brio_ctl_props brio_ctl_props_inst (.MCLK(MCLK), .RESET_N(RESET_N), .REG_RD(REG_RD),
	.REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA), .CYC_BUSY(CYC_BUSY), .CYC_DONE(CYC_DONE),
	.CYC_ERR(CYC_ERR), .CYC_RDATA(CYC_RDATA), .ROM_CS_N(ROM_CS_N), .SECOND_MODULE_SLOT_CS_N(SECOND_MODULE_SLOT_CS_N),
	.FAULT_RECOVERY(FAULT_RECOVERY), .SECOND_MODULE_SLOT_TYPE(SECOND_MODULE_SLOT_TYPE), .SECOND_MODULE_SLOT_DOUBLE_SIDED(SECOND_MODULE_SLOT_DOUBLE_SIDED),
	.SECOND_MODULE_SLOT_EN(SECOND_MODULE_SLOT_EN), .SECOND_MODULE_SLOT_MUX_MODE4(SECOND_MODULE_SLOT_MUX_MODE4), .SECOND_MODULE_SLOT_MUX_MODE(SECOND_MODULE_SLOT_MUX_MODE),
	.SECOND_MODULE_SLOT_EDO_ID_MODE(SECOND_MODULE_SLOT_EDO_ID_MODE), .SECOND_MODULE_SLOT_BANK_INTERLEAVE(SECOND_MODULE_SLOT_BANK_INTERLEAVE),
	.SECOND_MODULE_SLOT_ADDR_MASK(SECOND_MODULE_SLOT_ADDR_MASK), .SECOND_MODULE_SLOT_BASE_ADDR(SECOND_MODULE_SLOT_BASE_ADDR),
	.SECOND_MODULE_SLOT_ACCESS_CLKS(SECOND_MODULE_SLOT_ACCESS_CLKS));

/* brio_mem_model.sv */
// Memory bus device model with optional ready throttling
`timescale 1ns/1ps
module brio_mem_model (
	input  wire logic        clk,
	input  wire logic        cs_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [31:0] addr,
	input  wire logic [9:0]  delay,
	output logic             ready,
	output logic      [7:0]  writes
);
	logic [9:0]  cnt = 10'h0;
	logic [31:0] last = 32'h0;
	logic [31:0] dq;
	initial writes = 8'h0;
	always @(posedge clk) begin
		cnt <= cs_n ? 10'h0 : (cnt == 10'h3FF ? cnt : cnt + 10'h1);
		last <= dq;
		if (!cs_n && !we_n && cnt == 10'h0)
			writes <= writes + 8'h1;
	end
	// Ready low for delay clocks after select; delay zero ties it high
	assign ready = !(!cs_n && cnt < delay);
	// Released bus shows the inverse of the last value
	assign dq = (!cs_n && !oe_n) ? (addr ^ 32'hA5A5_5A5A) : ~last;
endmodule

/* boot_rom_io_cycle_timing_bench.sv */
// Testbench for the boot ROM and I/O cycle timing block
`timescale 1ns/1ps
module boot_rom_io_cycle_timing_bench;
	logic        MCLK = 0, RESET_N = 0, REG_WR = 0, REG_RD = 0, CYC_REQ = 0, CYC_WRITE = 0;
	logic [8:0]  straps = 9'h001;
	logic [7:0]  REG_ADDR = 8'h0, writes, wc;
	logic [31:0] REG_WDATA = 0, CYC_ADDR = 0, CYC_WDATA = 0, REG_RDATA, CYC_RDATA, MEM_ADDR, dq, rd;
	logic        CYC_BUSY, CYC_DONE, CYC_ERR, IOCHRDY, ROM_CS_N, SECOND_MODULE_SLOT_CS_N, MEM_OE_N, MEM_WE_N, er;
	logic        saw = 0;
	logic [9:0]  wdelay = 10'h0;
	int          errors = 0, num_checks = 0, ncyc;

	always #10 MCLK = ~MCLK;
	always @(posedge MCLK)
		if (SECOND_MODULE_SLOT_CS_N === 1'b0)
			saw <= 1'b1;

	brio_ctl brio_ctl_inst (.MCLK(MCLK), .RESET_N(RESET_N), .MUXED_ADDR_DATA_BUS(straps), .REG_WR(REG_WR),
		.REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
		.CYC_REQ(CYC_REQ), .CYC_WRITE(CYC_WRITE), .CYC_ADDR(CYC_ADDR), .CYC_WDATA(CYC_WDATA),
		.CYC_BUSY(CYC_BUSY), .CYC_DONE(CYC_DONE), .CYC_ERR(CYC_ERR), .CYC_RDATA(CYC_RDATA),
		.IOCHRDY(IOCHRDY), .ROM_CS_N(ROM_CS_N), .SECOND_MODULE_SLOT_CS_N(SECOND_MODULE_SLOT_CS_N), .MEM_OE_N(MEM_OE_N),
		.MEM_WE_N(MEM_WE_N), .MEM_ADDR(MEM_ADDR), .MEM_DQ_IN(dq), .MEM_DQ_OUT(), .MEM_DQ_OE(),
		.FAULT_RECOVERY(), .SECOND_MODULE_SLOT_TYPE(), .SECOND_MODULE_SLOT_DOUBLE_SIDED(), .SECOND_MODULE_SLOT_EN(), .SECOND_MODULE_SLOT_MUX_MODE4(),
		.SECOND_MODULE_SLOT_MUX_MODE(), .SECOND_MODULE_SLOT_EDO_ID_MODE(), .SECOND_MODULE_SLOT_BANK_INTERLEAVE(), .SECOND_MODULE_SLOT_ADDR_MASK(),
		.SECOND_MODULE_SLOT_BASE_ADDR(), .SECOND_MODULE_SLOT_ACCESS_CLKS());
	brio_mem_model brio_mem_model_inst (.clk(MCLK), .cs_n(ROM_CS_N & SECOND_MODULE_SLOT_CS_N), .oe_n(MEM_OE_N),
		.we_n(MEM_WE_N), .addr(MEM_ADDR), .delay(wdelay), .ready(IOCHRDY), .writes(writes));
	assign dq = brio_mem_model_inst.dq;

	task automatic give_verdict;
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic do_reset(input logic [8:0] s);
		straps = s;
		RESET_N = 0;
		repeat (3) @(negedge MCLK);
		RESET_N = 1;
		repeat (6) @(negedge MCLK);
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge MCLK);
		REG_WR = 1;
		REG_ADDR = a;
		REG_WDATA = d;
		@(negedge MCLK);
		REG_WR = 0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(negedge MCLK);
		REG_RD = 1;
		REG_ADDR = a;
		@(negedge MCLK);
		REG_RD = 0;
		@(negedge MCLK);
		d = REG_RDATA;
	endtask
	task automatic cyc(input logic w, input logic [31:0] a, output logic [31:0] d, output logic e);
		@(negedge MCLK);
		CYC_REQ = 1;
		CYC_WRITE = w;
		CYC_ADDR = a;
		CYC_WDATA = ~a;
		@(negedge MCLK);
		CYC_REQ = 0;
		ncyc = 1;
		while (CYC_DONE !== 1'b1 && ncyc < 300) begin
			@(negedge MCLK);
			ncyc++;
		end
		if (ncyc >= 300) begin
			errors++;
			give_verdict();
		end
		d = CYC_RDATA;
		e = CYC_ERR;
	endtask

	task automatic t_regs;
		reg_rd(8'hE8, rd);
		chk(rd, 32'h0000_3C00);
		reg_rd(8'h40, rd);
		chk(rd, 32'h0);
		reg_wr(8'hE8, 32'hFFFF_FFFF);
		reg_rd(8'hE8, rd);
		chk(rd, 32'h03FF_FDFF);
		$display("t_regs done");
	endtask
	task automatic t_lengths;
		for (int i = 0; i < 4; i++) begin
			reg_wr(8'hE8, 32'h3C10 | (i[1] ? 32'h1EF : 32'h0));
			cyc(i[0], 32'h1FC2_0000, rd, er);
			chk(ncyc, i[1] ? 18 : 3);
			if (i == 2)
				chk(rd, 32'h1FC2_0000 ^ 32'hA5A5_5A5A);
		end
		$display("t_lengths done");
	endtask
	task automatic t_timeout;
		wdelay = 10'h3E8;
		reg_wr(8'hE8, 32'h3C0F);
		cyc(0, 32'h1FC2_0000, rd, er);
		chk(ncyc, 2);
		reg_wr(8'hE8, 32'h0813);
		cyc(0, 32'h1FC2_0000, rd, er);
		chk({er, rd}, 33'h1_0000_0000);
		chk(ncyc, 9);
		reg_rd(8'hE8, rd);
		chk(rd, 32'h0A13);
		wdelay = 10'h3;
		reg_wr(8'hE8, 32'h3C13);
		cyc(0, 32'h1FC3_0000, rd, er);
		chk({er, rd}, {1'b0, 32'h1FC3_0000 ^ 32'hA5A5_5A5A});
		reg_rd(8'hE8, rd);
		chk(rd, 32'h3C13);
		wdelay = 10'h0;
		$display("t_timeout done");
	endtask
	task automatic t_protect(input logic [31:0] base, input logic [31:0] bad);
		wc = writes;
		cyc(1, base, rd, er);
		chk({er, writes}, {1'b0, wc});
		cyc(1, base + 32'h0001_0000, rd, er);
		chk(writes, wc + 8'h1);
		cyc(0, bad, rd, er);
		chk({er, rd}, 33'h1_0000_0000);
		$display("t_protect done");
	endtask
	task automatic t_recovery;
		do_reset(9'h101);
		saw = 0;
		reg_rd(8'h18, rd);
		chk(rd, 32'h1F00_100E);
		t_protect(32'h1EC0_0000, 32'h2000_0000);
		chk(saw, 1);
		$display("t_recovery done");
	endtask

	initial begin
		do_reset(9'h001);
		t_regs();
		t_lengths();
		t_timeout();
		reg_wr(8'hE8, 32'h3C10);
		t_protect(32'h1FC0_0000, 32'h1FD0_0000);
		t_recovery();
		give_verdict();
	end
endmodule
